// ### testbench/cpg_cal_path_checker.sv
// port assertions of the calibration path
`timescale 1ns/1ns
`default_nettype none
`include "cpg_consts.svh"
module cpg_cal_path_checker
	import cpg_pkg::*;
#(
	parameter int NCH   = 3,
	parameter int CNT_W = 14
)
(
	input wire logic                   mclk,
	input wire logic                   rst,
	input wire logic [NCH-1:0]         mod_bits,
	input wire logic [`CPG_ADDR_W-1:0] reg_addr,
	input wire logic [`CPG_DATA_W-1:0] reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [`CPG_DATA_W-1:0] reg_rdata,
	input wire logic                   data_ready_n
);
	// ==========================================================
	// helpers
	// read of any channel's result register
	wire logic res_a = (reg_addr < 8'h18) && (reg_addr[2:0] inside {3'h5, 3'h6});
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================================
	// properties
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == '0;
	endproperty
	property p_unmapped;
		reg_rd && reg_addr == 8'h07 |=> reg_rdata == '0;
	endproperty
	property p_status;
		reg_rd && reg_addr == `CPG_ADDR_STATUS |=>
			reg_rdata[NCH] == !$past(data_ready_n) && reg_rdata[15:NCH+1] == '0;
	endproperty
	property p_data_ready_n_hold;
		!data_ready_n && !(reg_rd && res_a) |=> !data_ready_n;
	endproperty
	property p_echo_ocal_up;
		reg_wr && reg_addr == 8'h01 ##1 reg_rd && reg_addr == 8'h01
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	property p_echo_gcal_up;
		reg_wr && reg_addr == 8'h03 ##1 reg_rd && reg_addr == 8'h03
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	property p_echo_gcal_lo;
		reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
			|=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2);
	endproperty
	property p_echo_phase;
		reg_wr && reg_addr == 8'h00 ##1 reg_rd && reg_addr == 8'h00
			|=> reg_rdata[9:0] == $past(reg_wdata[9:0], 2);
	endproperty
	// ==========================================================
	// assertions and covers
	a_rdata_idle:
		assert property (p_rdata_idle) else $error("read data not idle");
	a_unmapped:
		assert property (p_unmapped) else $error("unmapped read not zero");
	a_status:
		assert property (p_status) else $error("status ready bit wrong");
	a_data_ready_n_hold:
		assert property (p_data_ready_n_hold) else $error("ready released early");
	a_echo_ocal_up:
		assert property (p_echo_ocal_up) else $error("offset upper lost");
	a_echo_gcal_up:
		assert property (p_echo_gcal_up) else $error("gain upper lost");
	a_echo_gcal_lo:
		assert property (p_echo_gcal_lo) else $error("gain lower lost");
	a_echo_phase:
		assert property (p_echo_phase) else $error("phase field lost");
	c_ready: cover property ($fell(data_ready_n));
	c_res_read: cover property (reg_rd && res_a);
	c_status: cover property (reg_rd && reg_addr == `CPG_ADDR_STATUS);
endmodule
bind cpg_cal_path cpg_cal_path_checker #(
	.NCH   (NCH),
	.CNT_W (CNT_W)
) chk_u (
	.mclk         (mclk),
	.rst          (rst),
	.mod_bits     (mod_bits),
	.reg_addr     (reg_addr),
	.reg_wdata    (reg_wdata),
	.reg_wr       (reg_wr),
	.reg_rd       (reg_rd),
	.reg_rdata    (reg_rdata),
	.data_ready_n (data_ready_n)
);
`default_nettype wire

// ### testbench/cpg_cal_path_tb_top.sv
// self-checking bench of the calibration path
`timescale 1ns/1ns
`default_nettype none
`include "cpg_consts.svh"
module cpg_cal_path_tb_top;
	// ==========================================================
	// signals and tables
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  mod_bits;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        data_ready_n;
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	// phases and expected window shift at ratio 64
	logic [15:0] ph [5] = '{16'h0000, 16'h0005, 16'h03FD, 16'h0064, 16'h039C};
	logic [23:0] dl [5] = '{24'h0, 24'h5, 24'h3D, 24'h1F, 24'h20};
	// per case and channel: offset, gain, expected result
	logic [23:0] ofs [9] = '{0, 0, 0, 24'h100000, 24'h000010, 24'hFFFFFF,
		24'h100000, 24'h800000, 24'h000000};
	logic [23:0] gn [9] = '{0, 0, 0, 24'h800000, 24'h400000, 24'h400000,
		24'h400000, 24'h800000, 24'hFFFFFF};
	logic [23:0] ex [9] = '{24'h7FFFFF, 24'h000000, 24'h800000,
		24'h6FFFFF, 24'hFFFFF8, 24'hC00000, 24'h37FFFF, 24'h7FFFFF, 24'h800000};
	// reset view of one channel, offsets 0..4
	logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
	always #50 mclk = ~mclk;
	cpg_mod_src src_u (.mclk(mclk), .rst(rst), .mod_bits(mod_bits));
	cpg_cal_path #(.NCH(3), .CNT_W(14)) dut_u (
		.mclk         (mclk),
		.rst          (rst),
		.mod_bits     (mod_bits),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.data_ready_n (data_ready_n)
	);
	// ==========================================================
	// tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one write cycle, entered right after a rising edge; the strobe is
	// left high so a following write never re-drives it in one step,
	// and the next read lowers it
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
	endtask
	// read: data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
		@(posedge mclk);
	endtask
	task automatic wr_rb(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		wr(a, d);
		rd(a, r);
		check_val({8'h00, r}, {8'h00, d});
	endtask
	// release ready by a result read, then time its next fall
	task automatic wait_rdy(output int t);
		logic [15:0] r;
		int n;
		rd(8'h06, r);
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (data_ready_n !== 1'b0 && n < 200);
		check_val(24'(n < 200), 24'h1);
		t = cyc;
		@(posedge mclk);
	endtask
	task automatic chk_rst();
		logic [15:0] r;
		for (int i = 0; i < 15; i++)
		begin
			rd(8'((i / 5) * 8 + i % 5), r);
			check_val({8'h00, r}, {8'h00, rv[i % 5]});
		end
	endtask
	// ==========================================================
	// cycle limit
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			conclude();
		end
	end
	// ==========================================================
	// main sequence
	initial
	begin
		logic [15:0] r;
		logic [15:0] h;
		int t;
		int t0;
		t0 = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk_rst();
		rd(8'h07, r);
		check_val({8'h00, r}, 24'h0);
		$display("reset view done");
		wr(`CPG_ADDR_OSR, 16'h0000);
		foreach (ph[i])
		begin
			for (int c = 0; c < 3; c++)
				wr_rb(8'(c * 8), ph[i]);
			wait_rdy(t);
			wait_rdy(t);
			rd(`CPG_ADDR_STATUS, r);
			if (i == 0)
				t0 = t;
			check_val(24'((t - t0) % 64), dl[i]);
		end
		$display("phase timing done");
		for (int k = 0; k < 3; k++)
		begin
			for (int c = 0; k > 0 && c < 3; c++)
			begin
				wr_rb(8'(c * 8 + 1), ofs[k * 3 + c][23:8]);
				wr_rb(8'(c * 8 + 2), {8'h00, ofs[k * 3 + c][7:0]});
				wr_rb(8'(c * 8 + 3), gn[k * 3 + c][23:8]);
				wr_rb(8'(c * 8 + 4), {8'h00, gn[k * 3 + c][7:0]});
			end
			wait_rdy(t);
			wait_rdy(t);
			for (int c = 0; c < 3; c++)
			begin
				rd(8'(c * 8 + 5), h);
				rd(8'(c * 8 + 6), r);
				check_val({h, r[7:0]}, ex[k * 3 + c]);
			end
			$display("calibration case %0d done", k);
		end
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk_rst();
		$display("second reset done");
		conclude();
	end
endmodule
`default_nettype wire

// ### testbench/cpg_mod_src.sv
// modulator bitstream source standing at the far side of the path
`timescale 1ns/1ns
`default_nettype none
module cpg_mod_src
(
	input  wire logic       mclk,
	input  wire logic       rst,
	output logic [2:0]      mod_bits
);
	// ==========================================================
	// bit patterns
	// ch0 steady +1, ch1 alternating (zero sum over any even window),
	// ch2 steady -1; steady patterns make results phase independent
	always_ff @(posedge mclk)
	begin
		if (rst)
			mod_bits <= 3'h1;
		else
			mod_bits <= {1'b0, ~mod_bits[1], 1'b1};
	end
endmodule
`default_nettype wire

// ### verilog/cpg_cal_core.sv
// offset subtraction, gain multiply and saturation
`timescale 1ns/1ns
`default_nettype none
`include "cpg_consts.svh"
module cpg_cal_core
	import cpg_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire cpg_conv_t   conv_in,
	input  wire logic [23:0] channel_offset_coeff,
	input  wire logic [23:0] channel_gain_coeff,
	output cpg_conv_t        conv_out
);
	// ==========================================================
	// stage one: offset first, kept 25 bits so nothing wraps
	logic signed [24:0] diff_r;  // result minus offset
	logic               vld_r;   // stage one strobe
	logic signed [49:0] prod;    // diff times gain
	logic signed [49:0] shifted; // back to result scale

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			diff_r <= 25'sh0000000;
			vld_r  <= 1'b0;
		end
		else
		begin
			diff_r <= 25'($signed(conv_in.data)) - 25'($signed(channel_offset_coeff));
			vld_r  <= conv_in.valid;
		end
	end

	// gain is unsigned with 23 fractional bits
	always_comb
	begin
		prod    = 50'(diff_r) * $signed({26'h0, channel_gain_coeff});
		shifted = prod >>> `CPG_GAIN_FRAC;
	end

	// ==========================================================
	// stage two: clip to signed 24-bit range
	always_ff @(posedge mclk)
	begin
		if (rst)
			conv_out <= '0;
		else
		begin
			conv_out.valid <= vld_r;
			if (shifted > 50'sh7FFFFF)
				conv_out.data <= 24'h7FFFFF;
			else if (shifted < -50'sh800000)
				conv_out.data <= 24'h800000;
			else
				conv_out.data <= shifted[23:0];
		end
	end
endmodule
`default_nettype wire

// ### verilog/cpg_cal_path.sv
// top of the multichannel phase, offset and gain calibration path
`timescale 1ns/1ns
`default_nettype none
`include "cpg_consts.svh"
// Behaviour
// - phase field is signed modulator cycle count
// - every channel has its own phase field
// - zero phase difference keeps windows aligned
// - phase shifts window, length stays one ratio
// - range minus half to half minus one
// - ratios above 1024 limited to -512..511
// - out-of-range phase saturates, never wraps
// - phases move the data ready timing
// - subtract per-channel offset before output
// - offset is signed 24-bit value
// - multiply by per-channel gain before output
// - gain unsigned 24-bit, 800000h equals one
// - corrections always on, no enable
// - offsets reset to zero
// - gains reset to exactly one
// - filter output feeds calibration directly
module cpg_cal_path
	import cpg_pkg::*;
#(
	parameter int NCH   = 3,
	parameter int CNT_W = 14
)
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic [NCH-1:0]        mod_bits,
	input  wire logic [`CPG_ADDR_W-1:0] reg_addr,
	input  wire logic [`CPG_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [`CPG_DATA_W-1:0]     reg_rdata,
	output logic                       data_ready_n
);
	// ==========================================================
	// register storage
	logic [9:0]       channel_config_reg [NCH];  // phase fields
	logic [15:0]      offset_coeff_upper_reg [NCH]; // offset [23:8]
	logic [7:0]       offset_coeff_lower_reg [NCH]; // offset [7:0]
	logic [15:0]      gain_coeff_upper_reg [NCH];   // gain [23:8]
	logic [7:0]       gain_coeff_lower_reg [NCH];   // gain [7:0]
	logic [23:0]      result_r [NCH];               // latest corrected words
	logic [2:0]       osr_code_r;                   // oversampling ratio code
	logic [CNT_W-1:0] ref_cnt_r;                    // zero-phase reference count
	logic [CNT_W:0]   osr_val;                      // decoded ratio
	logic [NCH-1:0]   fresh_r;                      // result since last ready
	logic [NCH-1:0]   fresh_nxt;                    // next fresh flags
	logic [NCH-1:0]   done;                         // corrected word strobes
	logic             all_fresh;                    // every channel updated
	logic             ready_clr;                    // host read of results
	logic             data_ready_n_nxt;             // next ready level
	logic [`CPG_DATA_W-1:0] rdata_nxt;              // read mux
	cpg_conv_t        conv_raw [NCH];               // window outputs
	cpg_conv_t        conv_cal [NCH];               // corrected outputs

	// ==========================================================
	// address decode helpers
	function automatic logic hit(input logic [`CPG_ADDR_W-1:0] a, input int ch,
		input logic [7:0] off);
		hit = (a == 8'(ch * 8) + off);
	endfunction

	// ==========================================================
	// common reference counter, one tick per modulator cycle
	always_comb
	begin
		osr_val = (CNT_W+1)'(1) << (`CPG_OSR_LOG_BASE + 5'(osr_code_r));
	end

	// wraps at the ratio; a shrink of the ratio restarts it
	always_ff @(posedge mclk)
	begin
		if (rst)
			ref_cnt_r <= '0;
		else if ({1'b0, ref_cnt_r} >= osr_val - (CNT_W+1)'(1))
			ref_cnt_r <= '0;
		else
			ref_cnt_r <= ref_cnt_r + CNT_W'(1);
	end

	// ==========================================================
	// ratio register, applies to all channels
	always_ff @(posedge mclk)
	begin
		if (rst)
			osr_code_r <= `CPG_OSR_CODE_RST;
		else if (reg_wr && reg_addr == `CPG_ADDR_OSR)
		begin
			// a three-bit code reaches 8192 at most, so every code is legal;
			// the largest ratio still fits a CNT_W of 14
			osr_code_r <= reg_wdata[2:0];
		end
	end

	// ==========================================================
	// per-channel registers and datapath
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_ch
			// phase and coefficient registers of one channel
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					channel_config_reg[g]     <= 10'h000;
					offset_coeff_upper_reg[g] <= 16'(`CPG_OCAL_RST >> `CPG_UP_LSB);
					offset_coeff_lower_reg[g] <= 8'(`CPG_OCAL_RST);
					gain_coeff_upper_reg[g]   <= 16'(`CPG_GCAL_RST >> `CPG_UP_LSB);
					gain_coeff_lower_reg[g]   <= 8'(`CPG_GCAL_RST);
				end
				else if (reg_wr)
				begin
					if (hit(reg_addr, g, `CPG_OFF_CFG))
						channel_config_reg[g] <= reg_wdata[`CPG_PHASE_MSB:0];
					if (hit(reg_addr, g, `CPG_OFF_OCAL_UP))
						offset_coeff_upper_reg[g] <= reg_wdata;
					if (hit(reg_addr, g, `CPG_OFF_OCAL_LO))
						offset_coeff_lower_reg[g] <= reg_wdata[7:0];
					if (hit(reg_addr, g, `CPG_OFF_GCAL_UP))
						gain_coeff_upper_reg[g] <= reg_wdata;
					if (hit(reg_addr, g, `CPG_OFF_GCAL_LO))
						gain_coeff_lower_reg[g] <= reg_wdata[7:0];
				end
			end

			// shifted decimation window of this channel
			cpg_phase_window #(.CNT_W(CNT_W)) u_win
			(
				.mclk                 (mclk),
				.rst                  (rst),
				.mod_bit              (mod_bits[g]),
				.osr_code             (osr_code_r),
				.channel_phase_offset (channel_config_reg[g]),
				.ref_cnt              (ref_cnt_r),
				.conv                 (conv_raw[g])
			);

			// filter word goes straight into the correction stage
			cpg_cal_core u_cal
			(
				.mclk                 (mclk),
				.rst                  (rst),
				.conv_in              (conv_raw[g]),
				.channel_offset_coeff ({offset_coeff_upper_reg[g], offset_coeff_lower_reg[g]}),
				.channel_gain_coeff   ({gain_coeff_upper_reg[g], gain_coeff_lower_reg[g]}),
				.conv_out             (conv_cal[g])
			);

			assign done[g] = conv_cal[g].valid;

			// hold the latest corrected word for the host
			always_ff @(posedge mclk)
			begin
				if (rst)
					result_r[g] <= 24'h000000;
				else if (conv_cal[g].valid)
					result_r[g] <= conv_cal[g].data;
			end
		end
	endgenerate

	// ==========================================================
	// data ready: falls once the last-shifted channel delivers
	always_comb
	begin
		all_fresh = &(fresh_r | done);
		// a word landing in the clearing cycle is dropped; all flags clear
		if (all_fresh)
			fresh_nxt = '0;
		else
			fresh_nxt = fresh_r | done;
		ready_clr = 1'b0;
		for (int c = 0; c < NCH; c++)
		begin
			if (reg_rd && (hit(reg_addr, c, `CPG_OFF_RES_UP) || hit(reg_addr, c, `CPG_OFF_RES_LO)))
				ready_clr = 1'b1;
		end
		// a new ready beats a read in the same cycle
		if (all_fresh)
			data_ready_n_nxt = 1'b0;
		else if (ready_clr)
			data_ready_n_nxt = 1'b1;
		else
			data_ready_n_nxt = data_ready_n;
	end

	// fresh flags per channel
	always_ff @(posedge mclk)
	begin
		if (rst)
			fresh_r <= '0;
		else
			fresh_r <= fresh_nxt;
	end

	// active-low ready output
	always_ff @(posedge mclk)
	begin
		if (rst)
			data_ready_n <= 1'b1;
		else
			data_ready_n <= data_ready_n_nxt;
	end

	// ==========================================================
	// read mux; unmapped addresses and reserved bits read zero
	always_comb
	begin
		rdata_nxt = '0;
		if (reg_addr == `CPG_ADDR_OSR)
			rdata_nxt = {13'h0000, osr_code_r};
		if (reg_addr == `CPG_ADDR_STATUS)
			rdata_nxt = 16'({~data_ready_n, fresh_r});
		for (int c = 0; c < NCH; c++)
		begin
			if (hit(reg_addr, c, `CPG_OFF_CFG))
				rdata_nxt = {6'h00, channel_config_reg[c]};
			if (hit(reg_addr, c, `CPG_OFF_OCAL_UP))
				rdata_nxt = offset_coeff_upper_reg[c];
			if (hit(reg_addr, c, `CPG_OFF_OCAL_LO))
				rdata_nxt = {8'h00, offset_coeff_lower_reg[c]};
			if (hit(reg_addr, c, `CPG_OFF_GCAL_UP))
				rdata_nxt = gain_coeff_upper_reg[c];
			if (hit(reg_addr, c, `CPG_OFF_GCAL_LO))
				rdata_nxt = {8'h00, gain_coeff_lower_reg[c]};
			if (hit(reg_addr, c, `CPG_OFF_RES_UP))
				rdata_nxt = result_r[c][23:8];
			if (hit(reg_addr, c, `CPG_OFF_RES_LO))
				rdata_nxt = {8'h00, result_r[c][7:0]};
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= '0;
	end
endmodule
`default_nettype wire

// ### verilog/cpg_consts.svh
// constants of the channel phase, offset and gain calibration path
`ifndef CPG_CONSTS_SVH
`define CPG_CONSTS_SVH
// ==========================================================
// register bus
`define CPG_ADDR_W        8
`define CPG_DATA_W        16
`define CPG_CH_STRIDE     8'h08
`define CPG_OFF_CFG       8'h00
`define CPG_OFF_OCAL_UP   8'h01
`define CPG_OFF_OCAL_LO   8'h02
`define CPG_OFF_GCAL_UP   8'h03
`define CPG_OFF_GCAL_LO   8'h04
`define CPG_OFF_RES_UP    8'h05
`define CPG_OFF_RES_LO    8'h06
`define CPG_ADDR_OSR      8'h30
`define CPG_ADDR_STATUS   8'h31
// ==========================================================
// field positions and reset values
`define CPG_PHASE_MSB     9
`define CPG_UP_LSB        8
`define CPG_OCAL_RST      24'h000000
`define CPG_GCAL_RST      24'h800000
`define CPG_OSR_CODE_RST  3'h4
`define CPG_OSR_CODE_MAX  3'h0
`define CPG_OSR_LOG_BASE  5'h06
`define CPG_PHASE_CAP     11'h200
`define CPG_SCALE_BASE    5'h11
`define CPG_GAIN_FRAC     23
`endif

// ### verilog/cpg_phase_window.sv
// per-channel phase-clipped decimation window
`timescale 1ns/1ns
`default_nettype none
`include "cpg_consts.svh"
module cpg_phase_window
	import cpg_pkg::*;
#(
	parameter int CNT_W = 14
)
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             mod_bit,
	input  wire logic [2:0]       osr_code,
	input  wire logic [9:0]       channel_phase_offset,
	input  wire logic [CNT_W-1:0] ref_cnt,
	output cpg_conv_t             conv
);
	// ==========================================================
	// phase range and clipping
	logic        [CNT_W:0]   osr_val;   // oversampling ratio
	logic signed [10:0]      half;      // half range, capped
	logic signed [10:0]      ph_in;     // programmed phase
	logic signed [10:0]      ph_clip;   // saturated phase
	logic signed [CNT_W+1:0] tgt_raw;   // osr-1+phase
	logic        [CNT_W-1:0] target;    // window end count
	logic signed [15:0]      acc_r;     // running +-1 sum
	logic signed [15:0]      sum;       // sum with this sample
	logic signed [31:0]      scaled;    // sum shifted to 24-bit scale
	logic        [4:0]       shamt;     // scale shift
	logic                    end_win;   // last sample of window

	// ratio is 64 times a power of two
	always_comb
	begin
		osr_val = (CNT_W+1)'(1) << (`CPG_OSR_LOG_BASE + 5'(osr_code));
		if (osr_val > (CNT_W+1)'(1024))
			half = `CPG_PHASE_CAP;
		else
			half = 11'(osr_val >> 1);
		ph_in = {channel_phase_offset[9], channel_phase_offset};
		// saturate instead of wrapping
		if (ph_in < -half)
			ph_clip = -half;
		else if (ph_in > half - 11'sd1)
			ph_clip = half - 11'sd1;
		else
			ph_clip = ph_in;
	end

	// ==========================================================
	// window end: shifted against the common reference count
	always_comb
	begin
		tgt_raw = $signed({1'b0, osr_val}) - 16'sd1 + 16'(ph_clip);
		if (tgt_raw >= $signed({1'b0, osr_val}))
			tgt_raw = tgt_raw - $signed({1'b0, osr_val});
		target  = tgt_raw[CNT_W-1:0];
		end_win = (ref_cnt == target);
		sum     = acc_r + (mod_bit ? 16'sd1 : -16'sd1);
		shamt   = `CPG_SCALE_BASE - 5'(osr_code);
		scaled  = 32'(sum) <<< shamt;
	end

	// ==========================================================
	// accumulator: each window spans exactly one ratio of samples
	always_ff @(posedge mclk)
	begin
		if (rst)
			acc_r <= 16'sh0000;
		else if (end_win)
			acc_r <= 16'sh0000;
		else
			acc_r <= sum;
	end

	// conversion word, full positive code clipped to 24 bits
	always_ff @(posedge mclk)
	begin
		if (rst)
			conv <= '0;
		else
		begin
			conv.valid <= end_win;
			if (scaled > 32'sh007FFFFF)
				conv.data <= 24'h7FFFFF;
			else
				conv.data <= scaled[23:0];
		end
	end
endmodule
`default_nettype wire

// ### verilog/cpg_pkg.sv
// types shared by the calibration path modules
package cpg_pkg;
	// one conversion word with its strobe
	typedef struct packed
	{
		logic        valid;
		logic [23:0] data;
	} cpg_conv_t;
endpackage
